// ===== core/crs_pkg.sv
// Constants, types and state layout of the core register set.
//
// Contract
// - Eight-bit work register holds operands and results.
// - Effective address is pointer plus 8-bit offset.
// - Pointer low ten bits address; top bit selects. Data range keeps only the low byte of the sum.
// - Bit 10 picks data or program range.
// - Indexed writes never alter the code store.
// - Ten-bit instruction counter resets to 0x000; its fetch address is 0xC00.
// - Four-bit stack pointer, stack within 0x30-0x3F.
// - Stack pointer resets to 0xF.
// - Push decrements stack pointer by two.
// - Pull increments stack pointer by two.
// - Stack pointer marks next free location.
// - Call pushes return address, low byte first.
// - Return pulls address into instruction counter.
// - Status holds carry, nibble, zero, sign, mask, update.
// - Instructions update condition flags automatically.
// - Pointer, stack pointer, status are memory mapped.
// - Zero flag set on zero result.
// - Sign flag copies result most significant bit.
// - Nibble flag marks carry out of bit 3.
// - Interrupt mask cleared by reset, set by software.
package crs_pkg;

   // ***********************************************************
   // Widths, addresses and field positions
   // ***********************************************************
   localparam int unsigned DW  = 8;
   localparam int unsigned MPW = 11;
   localparam int unsigned PCW = 10;
   localparam int unsigned SPW = 4;
   localparam int unsigned AW  = 12;
   localparam int unsigned NW  = 4;

   localparam int unsigned MP_SEG = 10;
   localparam int unsigned MP_HIW = 3;
   localparam int unsigned SR_C   = 0;
   localparam int unsigned SR_H   = 1;
   localparam int unsigned SR_Z   = 2;
   localparam int unsigned SR_N   = 3;
   localparam int unsigned SR_G   = 4;
   localparam int unsigned SR_R   = 5;

   localparam logic [AW-1:0]  PROG_BASE = 12'hC00;
   localparam logic [AW-1:0]  PC_RESET  = 12'hC00;
   localparam logic [DW-1:0]  STK_BASE  = 8'h30;
   localparam logic [SPW-1:0] SP_RESET  = 4'hF;
   localparam logic [SPW-1:0] SP_ONE    = 4'h1;
   localparam logic [SPW-1:0] SP_STEP   = 4'h2;
   localparam logic [DW-1:0]  SR_RESET  = 8'h00;
   localparam logic [DW-1:0]  SR_WMASK  = 8'h1F;
   localparam logic [MPW-1:0] MP_RESET  = 11'h000;
   localparam logic [DW-1:0]  WK_RESET  = 8'h00;
   localparam logic [DW-1:0]  INC_ONE   = 8'h01;
   localparam logic [DW-1:0]  DEC_ONE   = 8'hFF;

   localparam logic [DW-1:0] MAP_MP_LO = 8'hFC;
   localparam logic [DW-1:0] MAP_MP_HI = 8'hFD;
   localparam logic [DW-1:0] MAP_SP    = 8'hFE;
   localparam logic [DW-1:0] MAP_SR    = 8'hFF;

   // ***********************************************************
   // Types
   // ***********************************************************
   typedef enum logic [4:0] {
      OP_IDLE, OP_LDI, OP_ADD, OP_SUB, OP_AND, OP_XOR, OP_INC,
      OP_DEC, OP_SETC, OP_CLRC, OP_SETG, OP_CLRG, OP_DRD, OP_DWR,
      OP_XRD, OP_XWR, OP_STEP, OP_JUMP, OP_CALL, OP_EXIT
   } crs_op_type;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RD_WAIT, ST_PUSH_HI, ST_PULL_HI, ST_PULL_LO
   } crs_st_type;

   typedef struct packed {
      crs_op_type     op;
      logic [DW-1:0]  data;
      logic [DW-1:0]  addr;
      logic [PCW-1:0] target;
   } crs_cmd_type;

   typedef struct packed {
      logic          re;
      logic          we;
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
   } crs_mem_type;

   typedef struct packed {
      crs_st_type     st;
      logic           busy;
      logic [DW-1:0]  work;
      logic [MPW-1:0] mptr;
      logic [PCW-1:0] pc;
      logic [SPW-1:0] sp;
      logic [DW-1:0]  sr;
      logic [DW-1:0]  hold;
      crs_mem_type    mem;
      logic [DW-1:0]  rdat;
      logic           rvld;
      logic           blk;
   } crs_state_type;

endpackage : crs_pkg

// ===== core/crs_core_regs.sv
// Programming-model register set of the 8-bit core: work, pointer, counter, stack, status.
module crs_core_regs
   import crs_pkg::*;
(
   input  wire logic           clk,
   input  wire logic           rst_n,
   input  wire logic           cmd_valid,
   input  wire crs_cmd_type    cmd,
   input  wire logic           mem_rvalid,
   input  wire logic [DW-1:0]  mem_rdata,
   input  wire logic           ee_write_busy,
   output      crs_mem_type    mem,
   output      logic [DW-1:0]  rd_data,
   output      logic           rd_valid,
   output      logic           busy,
   output      logic [DW-1:0]  work_reg,
   output      logic [PCW-1:0] instr_counter,
   output      logic [AW-1:0]  fetch_addr,
   output      logic [SPW-1:0] stack_ptr,
   output      logic [DW-1:0]  status_reg,
   output      logic [MPW-1:0] memory_pointer,
   output      logic           prog_wr_blocked
);

   // ***********************************************************
   // Address helpers
   // ***********************************************************

   // Indexed effective address. Only the low ten pointer bits take
   // part in the sum; the top bit only chooses the segment.
   function automatic logic [AW-1:0] eff_addr(
      input logic [MPW-1:0] p,
      input logic [DW-1:0]  off
   );
      logic [PCW-1:0] sum;
      sum = p[PCW-1:0] + PCW'(off);
      if (p[MP_SEG]) begin
         eff_addr = PROG_BASE | AW'(sum);
      end else begin
         eff_addr = AW'(sum[DW-1:0]);
      end
   endfunction : eff_addr

   function automatic logic [AW-1:0] stk_addr(
      input logic [SPW-1:0] p
   );
      stk_addr = AW'(STK_BASE | DW'(p));
   endfunction : stk_addr

   // Sign and zero follow every result that reaches the work register.
   function automatic logic [DW-1:0] zn(
      input logic [DW-1:0] sr,
      input logic [DW-1:0] res
   );
      logic [DW-1:0] f;
      f = sr;
      f[SR_Z] = (res == '0);
      f[SR_N] = res[DW-1];
      zn = f;
   endfunction : zn

   // ***********************************************************
   // State
   // ***********************************************************
   crs_state_type s_r;
   crs_state_type s_nxt;

   localparam crs_state_type S_RESET = '{
      st:   ST_IDLE,
      busy: 1'b0,
      work: WK_RESET,
      mptr: MP_RESET,
      pc:   PC_RESET[PCW-1:0],
      sp:   SP_RESET,
      sr:   SR_RESET,
      hold: WK_RESET,
      mem:  '0,
      rdat: WK_RESET,
      rvld: 1'b0,
      blk:  1'b0
   };

   // ***********************************************************
   // Next-state logic
   // ***********************************************************
   always_comb begin
      logic [DW:0]   sum;
      logic [NW:0]   nib;
      logic [DW-1:0] opb;
      logic          cin;
      logic          arith;
      logic [AW-1:0] ea;
      sum   = '0;
      nib   = '0;
      opb   = cmd.data;
      cin   = s_r.sr[SR_C];
      arith = 1'b0;
      ea    = eff_addr(s_r.mptr, cmd.addr);
      s_nxt = s_r;
      s_nxt.mem.re = 1'b0;
      s_nxt.mem.we = 1'b0;
      s_nxt.rvld   = 1'b0;
      s_nxt.blk    = 1'b0;
      // Update flag mirrors the data store's write status.
      s_nxt.sr[SR_R] = ee_write_busy;

      unique case (s_r.st)
         ST_IDLE: begin
            if (cmd_valid) begin
               unique case (cmd.op)
                  OP_ADD: begin
                     arith = 1'b1;
                  end
                  OP_SUB: begin
                     // Subtract as add of the complement; carry is not-borrow.
                     opb   = ~cmd.data;
                     arith = 1'b1;
                  end
                  OP_INC: begin
                     opb   = INC_ONE;
                     cin   = 1'b0;
                     arith = 1'b1;
                  end
                  OP_DEC: begin
                     opb   = DEC_ONE;
                     cin   = 1'b0;
                     arith = 1'b1;
                  end
                  OP_LDI: begin
                     s_nxt.work = cmd.data;
                     s_nxt.sr   = zn(s_nxt.sr, cmd.data);
                  end
                  OP_AND: begin
                     s_nxt.work = s_r.work & cmd.data;
                     s_nxt.sr   = zn(s_nxt.sr, s_r.work & cmd.data);
                  end
                  OP_XOR: begin
                     s_nxt.work = s_r.work ^ cmd.data;
                     s_nxt.sr   = zn(s_nxt.sr, s_r.work ^ cmd.data);
                  end
                  OP_SETC: begin
                     s_nxt.sr[SR_C] = 1'b1;
                  end
                  OP_CLRC: begin
                     s_nxt.sr[SR_C] = 1'b0;
                  end
                  OP_SETG: begin
                     s_nxt.sr[SR_G] = 1'b1;
                  end
                  OP_CLRG: begin
                     s_nxt.sr[SR_G] = 1'b0;
                  end
                  OP_DRD: begin
                     unique case (cmd.addr)
                        MAP_MP_LO: begin
                           s_nxt.rdat = s_r.mptr[DW-1:0];
                           s_nxt.rvld = 1'b1;
                        end
                        MAP_MP_HI: begin
                           s_nxt.rdat = DW'(s_r.mptr[PCW-1:DW]);
                           s_nxt.rvld = 1'b1;
                        end
                        MAP_SP: begin
                           s_nxt.rdat = DW'(s_r.sp);
                           s_nxt.rvld = 1'b1;
                        end
                        MAP_SR: begin
                           s_nxt.rdat = s_r.sr;
                           s_nxt.rvld = 1'b1;
                        end
                        default: begin
                           s_nxt.mem.re   = 1'b1;
                           s_nxt.mem.addr = AW'(cmd.addr);
                           s_nxt.st       = ST_RD_WAIT;
                        end
                     endcase
                  end
                  OP_DWR: begin
                     unique case (cmd.addr)
                        MAP_MP_LO: begin
                           s_nxt.mptr[DW-1:0] = cmd.data;
                        end
                        MAP_MP_HI: begin
                           s_nxt.mptr[MPW-1:DW] = cmd.data[MP_HIW-1:0];
                        end
                        MAP_SP: begin
                           s_nxt.sp = cmd.data[SPW-1:0];
                        end
                        MAP_SR: begin
                           s_nxt.sr = (cmd.data & SR_WMASK) | (s_nxt.sr & ~SR_WMASK);
                        end
                        default: begin
                           s_nxt.mem.we    = 1'b1;
                           s_nxt.mem.addr  = AW'(cmd.addr);
                           s_nxt.mem.wdata = cmd.data;
                        end
                     endcase
                  end
                  OP_XRD: begin
                     s_nxt.mem.re   = 1'b1;
                     s_nxt.mem.addr = ea;
                     s_nxt.st       = ST_RD_WAIT;
                  end
                  OP_XWR: begin
                     if (s_r.mptr[MP_SEG]) begin
                        s_nxt.blk = 1'b1;
                     end else begin
                        s_nxt.mem.we    = 1'b1;
                        s_nxt.mem.addr  = ea;
                        s_nxt.mem.wdata = s_r.work;
                     end
                  end
                  OP_STEP: begin
                     s_nxt.pc = s_r.pc + PCW'(1);
                  end
                  OP_JUMP: begin
                     s_nxt.pc = cmd.target;
                  end
                  OP_CALL: begin
                     s_nxt.mem.we    = 1'b1;
                     s_nxt.mem.addr  = stk_addr(s_r.sp);
                     s_nxt.mem.wdata = s_r.pc[DW-1:0];
                     s_nxt.hold      = DW'(s_r.pc[PCW-1:DW]);
                     s_nxt.pc        = cmd.target;
                     s_nxt.st        = ST_PUSH_HI;
                  end
                  OP_EXIT: begin
                     // High byte pulled first, reversing the push.
                     s_nxt.mem.re   = 1'b1;
                     s_nxt.mem.addr = stk_addr(s_r.sp + SP_ONE);
                     s_nxt.st       = ST_PULL_HI;
                  end
                  OP_IDLE: begin
                  end
               endcase

               if (arith) begin
                  sum = {1'b0, s_r.work} + {1'b0, opb} + (DW+1)'(cin);
                  nib = {1'b0, s_r.work[NW-1:0]} + {1'b0, opb[NW-1:0]} + (NW+1)'(cin);
                  s_nxt.work = sum[DW-1:0];
                  s_nxt.sr   = zn(s_nxt.sr, sum[DW-1:0]);
                  s_nxt.sr[SR_H] = nib[NW];
                  if (cmd.op == OP_ADD || cmd.op == OP_SUB) begin
                     s_nxt.sr[SR_C] = sum[DW];
                  end
               end
            end
         end

         ST_RD_WAIT: begin
            if (mem_rvalid) begin
               s_nxt.work = mem_rdata;
               s_nxt.sr   = zn(s_nxt.sr, mem_rdata);
               s_nxt.rdat = mem_rdata;
               s_nxt.rvld = 1'b1;
               s_nxt.st   = ST_IDLE;
            end
         end

         ST_PUSH_HI: begin
            s_nxt.mem.we    = 1'b1;
            s_nxt.mem.addr  = stk_addr(s_r.sp - SP_ONE);
            s_nxt.mem.wdata = s_r.hold;
            s_nxt.sp = s_r.sp - SP_STEP;
            s_nxt.st = ST_IDLE;
         end

         ST_PULL_HI: begin
            if (mem_rvalid) begin
               s_nxt.hold     = mem_rdata;
               s_nxt.mem.re   = 1'b1;
               s_nxt.mem.addr = stk_addr(s_r.sp + SP_STEP);
               s_nxt.st       = ST_PULL_LO;
            end
         end

         ST_PULL_LO: begin
            if (mem_rvalid) begin
               s_nxt.pc = {s_r.hold[PCW-DW-1:0], mem_rdata};
               s_nxt.sp = s_r.sp + SP_STEP;
               s_nxt.st = ST_IDLE;
            end
         end
      endcase

      s_nxt.busy = (s_nxt.st != ST_IDLE);
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= S_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ***********************************************************
   // Outputs, all taken straight from the state register
   // ***********************************************************
   assign mem             = s_r.mem;
   assign rd_data         = s_r.rdat;
   assign rd_valid        = s_r.rvld;
   assign busy            = s_r.busy;
   assign work_reg        = s_r.work;
   assign instr_counter   = s_r.pc;
   // The counter lives in the program segment, so its fetch address
   // is the segment base plus the counter.
   assign fetch_addr      = PROG_BASE | AW'(s_r.pc);
   assign stack_ptr       = s_r.sp;
   assign status_reg      = s_r.sr;
   assign memory_pointer  = s_r.mptr;
   assign prog_wr_blocked = s_r.blk;

endmodule : crs_core_regs

// ===== sim/crs_core_regs_checker.sv
// Port-level assertions on the core register set, bound to its top module.
module crs_core_regs_checker
   import crs_pkg::*;
(
   input wire logic           clk,
   input wire logic           rst_n,
   input wire logic           cmd_valid,
   input wire crs_cmd_type    cmd,
   input wire logic           mem_rvalid,
   input wire logic [DW-1:0]  mem_rdata,
   input wire logic           ee_write_busy,
   input wire crs_mem_type    mem,
   input wire logic [DW-1:0]  rd_data,
   input wire logic           rd_valid,
   input wire logic           busy,
   input wire logic [DW-1:0]  work_reg,
   input wire logic [PCW-1:0] instr_counter,
   input wire logic [AW-1:0]  fetch_addr,
   input wire logic [SPW-1:0] stack_ptr,
   input wire logic [DW-1:0]  status_reg,
   input wire logic [MPW-1:0] memory_pointer,
   input wire logic           prog_wr_blocked
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic tk;
   assign tk = cmd_valid && !busy;
   sequence push_lo_s;
      mem.we && mem.addr == {4'h0, STK_BASE | {4'h0, $past(stack_ptr)}}
         && mem.wdata == $past(instr_counter[7:0]);
   endsequence
   sequence push_hi_s;
      mem.we && mem.addr == {4'h0, STK_BASE | {4'h0, $past(stack_ptr, 2) - SP_ONE}}
         && mem.wdata == {6'h00, $past(instr_counter[9:8], 2)};
   endsequence
   reset_vals_a:
   assert property ($rose(rst_n) |-> stack_ptr == SP_RESET && instr_counter == 10'h000
      && !status_reg[SR_G]) else $error("wrong register values after reset");
   fetch_map_a:
   assert property (fetch_addr == (PC_RESET | {2'h0, instr_counter}))
      else $error("fetch address not in program range");
   call_push_a:
   assert property (tk && cmd.op == OP_CALL |=> push_lo_s ##1 push_hi_s)
      else $error("return address push wrong");
   push_dec_a:
   assert property (tk && cmd.op == OP_CALL |-> ##2 stack_ptr == $past(stack_ptr, 2) - SP_STEP)
      else $error("stack pointer not lowered by two");
   ret_pull_a:
   assert property (tk && cmd.op == OP_EXIT |=> busy && mem.re
      && mem.addr == {4'h0, STK_BASE | {4'h0, $past(stack_ptr) + SP_ONE}})
      else $error("return pull address wrong");
   idx_addr_a:
   assert property (tk && cmd.op == OP_XRD |=> mem.re && mem.addr == ($past(memory_pointer[MP_SEG])
      ? (PROG_BASE | {2'h0, $past(memory_pointer[9:0]) + {2'h0, $past(cmd.addr)}})
      : {4'h0, $past(memory_pointer[7:0]) + $past(cmd.addr)})) else $error("bad indexed address");
   code_ro_a:
   assert property (tk && cmd.op == OP_XWR && memory_pointer[MP_SEG] |=> prog_wr_blocked && !mem.we)
      else $error("indexed write reached code store");
   add_res_a:
   assert property (tk && cmd.op == OP_ADD |=> work_reg == $past(work_reg) + $past(cmd.data)
      + $past(status_reg[SR_C]) && status_reg[SR_Z] == (work_reg == 8'h00)
      && status_reg[SR_N] == work_reg[7]) else $error("add result or flags wrong");
   sr_top_a:
   assert property ($past(rst_n) |-> status_reg[7:6] == 2'h0
      && status_reg[SR_R] == $past(ee_write_busy)) else $error("status upper bits wrong");
   map_read_a:
   assert property (tk && cmd.op == OP_DRD && cmd.addr == MAP_SR |=> rd_valid
      && rd_data == $past(status_reg)) else $error("mapped status read wrong");
endmodule : crs_core_regs_checker

bind crs_core_regs crs_core_regs_checker chk (.clk, .rst_n, .cmd_valid, .cmd, .mem_rvalid,
   .mem_rdata, .ee_write_busy, .mem, .rd_data, .rd_valid, .busy, .work_reg, .instr_counter,
   .fetch_addr, .stack_ptr, .status_reg, .memory_pointer, .prog_wr_blocked);

// ===== sim/crs_mem_model.sv
// Behavioural data and code memory answering the register set's read and write pulses.
module crs_mem_model
   import crs_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire crs_mem_type   mem,
   input  wire logic          slow,
   output      logic          mem_rvalid,
   output      logic [DW-1:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ***********************************************************
   // Storage and read return
   // ***********************************************************
   logic [DW-1:0] m [0:4095];
   logic [AW-1:0] a;
   int            cnt;
   // Read data toggles outside a return so a stale value never looks valid.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt        <= 0;
         mem_rvalid <= 1'b0;
         mem_rdata  <= 8'h00;
      end else begin
         mem_rvalid <= 1'b0;
         mem_rdata  <= ~mem_rdata;
         // Every write lands, so a write that leaks into the code store shows up.
         if (mem.we) m[mem.addr] <= mem.wdata;
         if (mem.re) begin
            a   <= mem.addr;
            cnt <= slow ? 4 : 1;
         end else if (cnt == 1) begin
            mem_rvalid <= 1'b1;
            mem_rdata  <= m[a];
            cnt        <= 0;
         end else if (cnt > 1) cnt <= cnt - 1;
      end
   end
endmodule : crs_mem_model

// ===== sim/mcu_core_register_set_tb.sv
// Self-checking bench for the core register set with a memory model on its far side.
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module mcu_core_register_set_tb import crs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic           clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0;
   logic           ee_write_busy = 1'b0, slow = 1'b0;
   crs_cmd_type    cmd = '0;
   crs_mem_type    mem;
   logic           mem_rvalid, rd_valid, busy, prog_wr_blocked;
   logic [DW-1:0]  mem_rdata, rd_data, work_reg, status_reg;
   logic [PCW-1:0] instr_counter;
   logic [AW-1:0]  fetch_addr;
   logic [SPW-1:0] stack_ptr;
   logic [MPW-1:0] memory_pointer;
   int             fail_count = 0, compares = 0;
   always #2 clk = ~clk;
   crs_core_regs uut (.clk, .rst_n, .cmd_valid, .cmd, .mem_rvalid, .mem_rdata, .ee_write_busy,
      .mem, .rd_data, .rd_valid, .busy, .work_reg, .instr_counter, .fetch_addr, .stack_ptr,
      .status_reg, .memory_pointer, .prog_wr_blocked);
   crs_mem_model mdl (.clk, .rst_n, .mem, .slow, .mem_rvalid, .mem_rdata);
   // ***********************************************************
   // Command driver and scenarios
   // ***********************************************************
   task automatic op(crs_op_type o, logic [DW-1:0] d = 8'h00, logic [DW-1:0] a = 8'h00,
                     logic [PCW-1:0] t = 10'h000);
      int n;
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd       = '{o, d, a, t};
      @(negedge clk);
      cmd_valid = 1'b0;
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(negedge clk);
         n++;
      end
      if (n == 50) `CHK(busy, 1'b0)
   endtask : op
   task automatic t_reset();
      `CHK(stack_ptr, SP_RESET)
      `CHK(fetch_addr, PC_RESET)
      `CHK(status_reg, SR_RESET)
      `CHK(work_reg, WK_RESET)
   endtask : t_reset
   task automatic t_alu();
      op(OP_CLRC);
      op(OP_LDI, 8'h0F);
      op(OP_ADD, 8'h01);
      `CHK(work_reg, 8'h10)
      `CHK(status_reg[SR_H], 1'b1)
      op(OP_LDI, 8'h80);
      `CHK(status_reg[SR_N], 1'b1)
      op(OP_ADD, 8'h80);
      `CHK(status_reg[3:0], 4'h5)
      op(OP_SETC);
      op(OP_LDI, 8'h10);
      op(OP_SUB, 8'h01);
      `CHK({work_reg, status_reg[SR_C]}, 9'h01F)
      op(OP_INC);
      `CHK({work_reg, status_reg[SR_H]}, 9'h021)
      op(OP_DEC);
      op(OP_AND, 8'h03);
      `CHK(work_reg, 8'h03)
      op(OP_XOR, 8'h03);
      `CHK(status_reg[SR_Z], 1'b1)
      op(OP_SETG);
      `CHK(status_reg[SR_G], 1'b1)
      op(OP_CLRG);
      `CHK(status_reg[SR_G], 1'b0)
   endtask : t_alu
   task automatic t_map();
      ee_write_busy = 1'b1;
      op(OP_DWR, 8'h05, MAP_SP);
      `CHK(stack_ptr, 4'h5)
      op(OP_DWR, 8'hFF, MAP_SR);
      op(OP_DRD, 8'h00, MAP_SR);
      `CHK(rd_valid, 1'b1)
      `CHK(rd_data, 8'h3F)
      ee_write_busy = 1'b0;
      op(OP_DWR, 8'h07, MAP_MP_HI);
      op(OP_DRD, 8'h00, MAP_MP_HI);
      `CHK(rd_data, 8'h03)
      `CHK(memory_pointer, 11'h700)
   endtask : t_map
   task automatic t_index();
      mdl.m[12'hF15] = 8'h5A;
      op(OP_DWR, 8'h10, MAP_MP_LO);
      op(OP_XWR, 8'h00, 8'h05);
      `CHK(prog_wr_blocked, 1'b1)
      @(negedge clk);
      `CHK(mdl.m[12'hF15], 8'h5A)
      op(OP_XRD, 8'h00, 8'h05);
      `CHK(work_reg, 8'h5A)
      op(OP_DWR, 8'h00, MAP_MP_HI);
      op(OP_LDI, 8'hAB);
      op(OP_XWR, 8'h00, 8'h05);
      @(negedge clk);
      `CHK(mdl.m[12'h015], 8'hAB)
      op(OP_LDI, 8'h00);
      op(OP_XRD, 8'h00, 8'h05);
      `CHK(work_reg, 8'hAB)
      slow = 1'b1;
      op(OP_LDI, 8'h00);
      op(OP_DRD, 8'h00, 8'h15);
      `CHK(work_reg, 8'hAB)
   endtask : t_index
   task automatic t_stack();
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      `CHK(stack_ptr, SP_RESET)
      op(OP_JUMP, 8'h00, 8'h00, 10'h122);
      op(OP_STEP);
      `CHK(instr_counter, 10'h123)
      op(OP_CALL, 8'h00, 8'h00, 10'h200);
      @(negedge clk);
      `CHK({mdl.m[12'h03F], mdl.m[12'h03E]}, 16'h2301)
      `CHK(stack_ptr, 4'hD)
      `CHK(instr_counter, 10'h200)
      op(OP_EXIT);
      `CHK(instr_counter, 10'h123)
      `CHK(stack_ptr, SP_RESET)
   endtask : t_stack
   task automatic stop_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      t_reset();
      t_alu();
      t_map();
      t_index();
      t_stack();
      stop_test();
   end
   // The whole sequence needs well under a thousand cycles.
   initial begin
      #20us;
      fail_count++;
      stop_test();
   end
endmodule : mcu_core_register_set_tb
